//--- hw/startup_ramp_defs.svh
// constants for the start-up ramp / timeout control block
// included by both design modules and the testbench; definitions only
`ifndef STARTUP_RAMP_DEFS_SVH
`define STARTUP_RAMP_DEFS_SVH
`define CMD_RAMP_TIME 8'h61
`define CMD_TIMEOUT_LIMIT 8'h62
`define CMD_TIMEOUT_ACTION 8'h63
`define RAMP_TIME_RESET 16'h0005
`define TIMEOUT_LIMIT_RESET 16'h0064
`define ACTION_RESET 8'hbf
`define ACTION_SELECT_BIT 7
`define ACTION_RETRY_HI 5
`define ACTION_RETRY_LO 3
`define ACTION_DELAY_CODE 3'h7
`define RETRY_NONE 3'h0
`define RETRY_ALWAYS 3'h7
`define MANT_MASK 16'h007f
`define BUCKET_TOP 7'd86
`define RESTART_RAMPS 4'd7
`define CLK_HZ 50000000
`define TICK_MS 1
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`endif

//--- hw/startup_ramp_pkg.sv
// types for the start-up ramp / timeout control block
// does not use startup_ramp_defs.svh; the state codes are given here
package startup_ramp_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_RAMP = 3'b001,
        ST_RUN = 3'b011,
        ST_WAIT = 3'b010,
        ST_LATCH = 3'b110
    } seq_state_e;
    typedef logic [6:0] mant_t;
endpackage

//--- hw/nv_backup_store.sv
// small non-volatile image of the persisted settings
// store and restore are single-cycle strobes; read data is registered
`timescale 1ns/1ps
`include "startup_ramp_defs.svh"
module nv_backup_store
    import startup_ramp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic store_in,
    input wire logic [6:0] ramp_in,
    input wire logic select_in,
    input wire logic retry_bit_in,
    output logic [6:0] ramp_out,
    output logic select_out,
    output logic retry_bit_out
);
    // only one retry bit is kept, the others are rebuilt from it
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ramp_out <= 7'(`RAMP_TIME_RESET);
            select_out <= 1'b1;
            retry_bit_out <= 1'b1;
        end
        else if (store_in)
        begin
            ramp_out <= ramp_in;
            select_out <= select_in;
            retry_bit_out <= retry_bit_in;
        end
    end
endmodule

//--- hw/startup_ramp_ctrl.sv
// start-up ramp time, start-up timeout timer and timeout fault response
// assumes a command decoder that presents single-cycle write/read strobes
// Notes on behaviour
// (R1) exponent fields read as fixed zero
// (R2) ramp time: seven writable bits, reset 5
// (R3) ramp mantissa maps to a supported bucket value
// (R4) timeout timer starts with ramp, checks undervoltage
// (R5) limit below ramp time refused, cml flagged
// (R6) zero limit disables timer and cross check
// (R7) limit: seven writable bits, reset 100
// (R8) restore-all returns limit to 100
// (R9) limit uses same buckets, zero means none
// (R10) timeout sets oth, vout word, timeout, alert
// (R11) action low three bits read ones
// (R12) default: shut down, retry after seven ramps
// (R13) select zero keeps regulating, flags still set
// (R14) select one shuts down, follows retry field
// (R15) retry 000 latches off until cleared
// (R16) retry 111 restarts soft start forever
// (R17) retry other than 000/111 refused, cml flagged
// (R18) only retry bit 5 persisted, regenerated
// (R19) store-all copies action register
// (R20) ramp time zero gives one millisecond
// (R21) ramp above nonzero limit refused
// (R22) millisecond tick prescaled from system clock
`timescale 1ns/1ps
`include "startup_ramp_defs.svh"
module startup_ramp_ctrl
    import startup_ramp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] cmd_in,
    input wire logic [15:0] wdata_in,
    input wire logic store_all_in,
    input wire logic restore_all_in,
    input wire logic enable_in,
    input wire logic uv_passed_in,
    input wire logic clear_faults_in,
    input wire logic alert_mask_in,
    output logic [15:0] rdata_out,
    output logic output_enable_out,
    output logic [6:0] ramp_ms_out,
    output logic startup_timeout_flag_out,
    output logic output_volt_word_flag_out,
    output logic other_fault_out,
    output logic cml_out,
    output logic invalid_data_out,
    output logic alert_n_out
);
    // bucket quantiser shared by ramp time and limit
    function automatic logic [6:0] bucket(input logic [6:0] m);
        logic [6:0] r;
        r = 7'd100;
        if (m <= 7'd6) r = (m == 7'd0) ? 7'd1 : m;
        else if (m <= 7'd9) r = 7'd7;
        else if (m <= 7'd12) r = 7'd10;
        else if (m <= 7'd17) r = 7'd14;
        else if (m <= 7'd22) r = 7'd19;
        else if (m <= 7'd32) r = 7'd27;
        else if (m <= 7'd44) r = 7'd37;
        else if (m <= 7'd62) r = 7'd52;
        else if (m <= `BUCKET_TOP) r = 7'd72;
        return r;
    endfunction

    mant_t ramp_time;
    mant_t limit;
    logic act_select;
    logic [2:0] retry_field;
    seq_state_e state;
    seq_state_e next_state;
    logic [15:0] tick_cnt;
    logic tick;
    logic [6:0] ms_cnt;
    logic [9:0] wait_cnt;
    logic [6:0] nv_ramp;
    logic nv_select;
    logic nv_retry;

    wire mant_t wr_mant = wdata_in[6:0];
    wire wr_ramp = wr_in && cmd_in == `CMD_RAMP_TIME;
    wire wr_limit = wr_in && cmd_in == `CMD_TIMEOUT_LIMIT;
    wire wr_act = wr_in && cmd_in == `CMD_TIMEOUT_ACTION;
    wire [2:0] wr_retry = wdata_in[`ACTION_RETRY_HI:`ACTION_RETRY_LO];
    // cross checks compare effective times; a zero limit skips them
    wire ramp_bad = limit != 7'd0 && bucket(wr_mant) > bucket(limit); // R21 R6
    wire limit_bad = wr_mant != 7'd0
        && bucket(wr_mant) < bucket(ramp_time); // R5 R6
    wire act_bad = wr_retry != `RETRY_NONE
        && wr_retry != `RETRY_ALWAYS; // R17
    wire reject = (wr_ramp && ramp_bad) || (wr_limit && limit_bad)
        || (wr_act && act_bad);
    wire [6:0] ramp_eff = bucket(ramp_time); // R3 R20
    wire [6:0] limit_eff = bucket(limit); // R9
    wire ms_tick = tick;
    wire timeout = state == ST_RAMP && ms_tick && limit != 7'd0
        && !uv_passed_in && ms_cnt + 7'd1 >= limit_eff; // R4 R6
    wire restart_done = state == ST_WAIT && ms_tick
        && wait_cnt + 10'd1 >= 10'(ramp_eff) * 10'(`RESTART_RAMPS); // R12

    // prescaler for the millisecond time base
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tick_cnt <= 16'h0000;
            tick <= 1'b0;
        end
        else
        begin
            tick <= tick_cnt == 16'(`TICK_CYCLES - 1); // R22
            tick_cnt <= (tick_cnt == 16'(`TICK_CYCLES - 1)) ? 16'h0000
                : tick_cnt + 16'h0001;
        end
    end

    // only the low seven mantissa bits are ever stored
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ramp_time <= 7'(`RAMP_TIME_RESET); // R2
            limit <= 7'(`TIMEOUT_LIMIT_RESET); // R7
            act_select <= 1'b1; // R14
            retry_field <= `RETRY_ALWAYS; // R16
        end
        else if (restore_all_in)
        begin
            ramp_time <= nv_ramp;
            limit <= 7'(`TIMEOUT_LIMIT_RESET); // R8
            act_select <= nv_select;
            retry_field <= {3{nv_retry}}; // R18
        end
        else
        begin
            if (wr_ramp && !ramp_bad)
                ramp_time <= wr_mant;
            if (wr_limit && !limit_bad)
                limit <= wr_mant;
            if (wr_act && !act_bad)
            begin
                act_select <= wdata_in[`ACTION_SELECT_BIT];
                retry_field <= wr_retry;
            end
        end
    end

    nv_backup_store u_nv (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .store_in(store_all_in), // R19
        .ramp_in(ramp_time),
        .select_in(act_select),
        .retry_bit_in(retry_field[2]), // R18
        .ramp_out(nv_ramp),
        .select_out(nv_select),
        .retry_bit_out(nv_retry)
    );

    // start-up sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            ST_OFF:
                if (enable_in)
                    next_state = ST_RAMP;
            ST_RAMP:
                if (!enable_in)
                    next_state = ST_OFF;
                else if (timeout && act_select) // R14
                    next_state = (retry_field == `RETRY_NONE)
                        ? ST_LATCH : ST_WAIT; // R15 R16
                else if (timeout || (uv_passed_in
                    && ms_cnt >= ramp_eff)) // R13
                    next_state = ST_RUN;
            ST_RUN:
                if (!enable_in)
                    next_state = ST_OFF;
            ST_WAIT:
                if (!enable_in)
                    next_state = ST_OFF;
                else if (restart_done)
                    next_state = ST_RAMP; // R16
            ST_LATCH:
                if (clear_faults_in || !enable_in)
                    next_state = ST_OFF; // R15
            default:
                next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= ST_OFF;
            ms_cnt <= 7'd0;
            wait_cnt <= 10'd0;
        end
        else
        begin
            state <= next_state;
            if (state != ST_RAMP)
                ms_cnt <= 7'd0; // R4
            else if (ms_tick && ms_cnt != 7'h7f)
                ms_cnt <= ms_cnt + 7'd1;
            if (state != ST_WAIT)
                wait_cnt <= 10'd0;
            else if (ms_tick)
                wait_cnt <= wait_cnt + 10'd1;
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            startup_timeout_flag_out <= 1'b0;
            output_volt_word_flag_out <= 1'b0;
            other_fault_out <= 1'b0;
            cml_out <= 1'b0;
            invalid_data_out <= 1'b0;
        end
        else
        begin
            startup_timeout_flag_out <= timeout
                || (startup_timeout_flag_out && !clear_faults_in); // R10
            output_volt_word_flag_out <= timeout
                || (output_volt_word_flag_out && !clear_faults_in); // R10
            other_fault_out <= timeout
                || (other_fault_out && !clear_faults_in); // R10
            cml_out <= reject || (cml_out && !clear_faults_in); // R5 R17
            invalid_data_out <= reject
                || (invalid_data_out && !clear_faults_in); // R5 R17
        end
    end

    wire [15:0] action_word = {8'h00, act_select, 1'b0, retry_field,
        `ACTION_DELAY_CODE}; // R11
    wire [15:0] rd_word = (cmd_in == `CMD_RAMP_TIME) ? {9'h000, ramp_time}
        : (cmd_in == `CMD_TIMEOUT_LIMIT) ? {9'h000, limit} // R1
        : (cmd_in == `CMD_TIMEOUT_ACTION) ? action_word : 16'h0000;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_out <= 16'h0000;
        else if (rd_in)
            rdata_out <= rd_word;
    end

    assign output_enable_out = state == ST_RAMP || state == ST_RUN;
    assign ramp_ms_out = ramp_eff;
    assign alert_n_out = !(((startup_timeout_flag_out || other_fault_out)
        && !alert_mask_in) || cml_out); // R10 R13

    AST_BAD_LIMIT_KEEPS: assert property (@(posedge clk_sys_in) // R5
        disable iff (rst_in) wr_limit && limit_bad && !restore_all_in
        |=> limit == $past(limit) && cml_out && invalid_data_out)
        else $error("refused limit write changed value or missed flags");
    AST_BAD_RAMP_KEEPS: assert property (@(posedge clk_sys_in) // R21
        disable iff (rst_in) wr_ramp && ramp_bad && !restore_all_in
        |=> ramp_time == $past(ramp_time) && cml_out)
        else $error("refused ramp write changed value");
    AST_BAD_RETRY: assert property (@(posedge clk_sys_in) // R17
        disable iff (rst_in) wr_act && act_bad && !restore_all_in
        |=> $stable(retry_field) && !alert_n_out)
        else $error("odd retry field accepted");
    AST_TIMEOUT_FLAGS: assert property (@(posedge clk_sys_in) // R10
        disable iff (rst_in) timeout |=> startup_timeout_flag_out
        && output_volt_word_flag_out && other_fault_out)
        else $error("timeout flags missing");
    AST_IGNORE_RUNS: assert property (@(posedge clk_sys_in) // R13
        disable iff (rst_in) timeout && !act_select && enable_in
        |=> state == ST_RUN && output_enable_out)
        else $error("ignore mode stopped regulating");
    AST_LATCH_OFF: assert property (@(posedge clk_sys_in) // R15
        disable iff (rst_in) state == ST_LATCH && !clear_faults_in
        && enable_in |=> state == ST_LATCH && !output_enable_out)
        else $error("latched-off output restarted");
    AST_ZERO_LIMIT: assert property (@(posedge clk_sys_in) // R6
        disable iff (rst_in) limit == 7'd0 |-> !timeout)
        else $error("timeout with timer disabled");
    AST_RETRY_EQUAL: assert property (@(posedge clk_sys_in) // R18
        disable iff (rst_in) retry_field == `RETRY_NONE
        || retry_field == `RETRY_ALWAYS)
        else $error("retry bits differ");
    AST_RESTORE_LIMIT: assert property (@(posedge clk_sys_in) // R8
        disable iff (rst_in) restore_all_in
        |=> limit == 7'(`TIMEOUT_LIMIT_RESET))
        else $error("restore did not reset limit");
    AST_TICK_PERIOD: assert property (@(posedge clk_sys_in) // R22
        disable iff (rst_in) tick |=> !tick [*8])
        else $error("tick too frequent");
    AST_CML_ALERT: assert property (@(posedge clk_sys_in) // R5
        disable iff (rst_in) cml_out |-> !alert_n_out)
        else $error("cml flag without alert");
    AST_MASKED_ALERT: assert property (@(posedge clk_sys_in) // R13
        disable iff (rst_in) startup_timeout_flag_out && !alert_mask_in
        |-> !alert_n_out)
        else $error("unmasked timeout without alert");
    AST_ACTION_FIXED: assert property (@(posedge clk_sys_in) // R11
        disable iff (rst_in) rd_in && cmd_in == `CMD_TIMEOUT_ACTION
        |=> rdata_out[2:0] == `ACTION_DELAY_CODE && !rdata_out[6])
        else $error("action fixed bits wrong");
    AST_UPPER_ZERO: assert property (@(posedge clk_sys_in) // R1
        disable iff (rst_in) rd_in |=> rdata_out[15:8] == 8'h00)
        else $error("exponent or upper bits not zero");
    AST_RAMP_START: assert property (@(posedge clk_sys_in) // R4
        disable iff (rst_in) state == ST_OFF && enable_in
        |=> state == ST_RAMP && ms_cnt == 7'd0)
        else $error("ramp did not start with a cleared timer");
    // shortest ramp gives the shortest restart wait, seven ticks
    AST_WAIT_MIN: assert property (@(posedge clk_sys_in) // R12
        disable iff (rst_in) state == ST_WAIT && wait_cnt < 10'd6
        |=> state != ST_RAMP)
        else $error("restart before seven ramp times");
    AST_RETRY_STORED: assert property (@(posedge clk_sys_in) // R19
        disable iff (rst_in) store_all_in
        |=> nv_retry == $past(retry_field[2]) && nv_select == $past(act_select))
        else $error("store did not copy action register");
    AST_RESTORE_RETRY: assert property (@(posedge clk_sys_in) // R18
        disable iff (rst_in) restore_all_in
        |=> retry_field == {3{$past(nv_retry)}})
        else $error("retry bits not rebuilt from stored bit");

    // main scenarios

    COV_TIMEOUT: cover property (@(posedge clk_sys_in)
        disable iff (rst_in) timeout);
    COV_RETRY: cover property (@(posedge clk_sys_in)
        disable iff (rst_in) state == ST_WAIT ##1 state == ST_RAMP);
    COV_REJECT: cover property (@(posedge clk_sys_in)
        disable iff (rst_in) reject);
    COV_IGNORE: cover property (@(posedge clk_sys_in)
        disable iff (rst_in) timeout && !act_select);
    COV_LATCH: cover property (@(posedge clk_sys_in)
        disable iff (rst_in) state == ST_LATCH);
endmodule

//--- tb/uv_plant.sv
// stand-in for the power stage: reports the output above its uv limit
// assumes the block's output enable and the single 50 MHz system clock
`timescale 1ns/1ps
module uv_plant
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic output_enable_in,
    input wire logic never_in,
    input wire logic [15:0] delay_in,
    output logic uv_passed_out
);
    logic [15:0] count;

    // output collapses on the next clock edge when the stage is turned off
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count <= 16'h0000;
            uv_passed_out <= 1'b0;
        end
        else if (!output_enable_in)
        begin
            count <= 16'h0000;
            uv_passed_out <= 1'b0;
        end
        else
        begin
            count <= (count == 16'hffff) ? count : count + 16'h0001;
            uv_passed_out <= !never_in && (count >= delay_in);
        end
    end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the start-up ramp / timeout control block
// assumes the 50000-cycle millisecond tick of the defs header
`timescale 1ns/1ps
`include "startup_ramp_defs.svh"
module tb_top;
    logic clk_sys_in, rst_in, wr_in, rd_in, store_all_in, restore_all_in;
    logic enable_in, uv_passed_in, clear_faults_in, alert_mask_in, never;
    logic [7:0] cmd_in;
    logic [15:0] wdata_in, rdata_out, w, d, prev;
    logic [6:0] ramp_ms_out, m;
    logic output_enable_out, startup_timeout_flag_out;
    logic output_volt_word_flag_out, other_fault_out, cml_out;
    logic invalid_data_out, alert_n_out;
    int failures, check_count, seed, i;
    int corner[10] = '{0, 1, 6, 7, 9, 10, 86, 87, 127, 12};

    startup_ramp_ctrl dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .wr_in(wr_in), .rd_in(rd_in), .cmd_in(cmd_in), .wdata_in(wdata_in),
        .store_all_in(store_all_in), .restore_all_in(restore_all_in),
        .enable_in(enable_in), .uv_passed_in(uv_passed_in),
        .clear_faults_in(clear_faults_in), .alert_mask_in(alert_mask_in),
        .rdata_out(rdata_out), .output_enable_out(output_enable_out),
        .ramp_ms_out(ramp_ms_out),
        .startup_timeout_flag_out(startup_timeout_flag_out),
        .output_volt_word_flag_out(output_volt_word_flag_out),
        .other_fault_out(other_fault_out), .cml_out(cml_out),
        .invalid_data_out(invalid_data_out), .alert_n_out(alert_n_out));

    uv_plant plant (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .output_enable_in(output_enable_out), .never_in(never),
        .delay_in(16'h000a), .uv_passed_out(uv_passed_in));

    initial
    begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [6:0] bucket(input logic [6:0] v);
        int tops[9] = '{9, 12, 17, 22, 32, 44, 62, 86, 127};
        int vals[9] = '{7, 10, 14, 19, 27, 37, 52, 72, 100};
        if (v <= 7'd6)
            return (v == 7'd0) ? 7'd1 : v;
        for (int k = 0; k < 9; k++)
            if (v <= tops[k])
                return vals[k][6:0];
        return 7'd100;
    endfunction

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        @(posedge clk_sys_in) #1 wr_in = 1'b1;
        cmd_in = c;
        wdata_in = v;
        @(posedge clk_sys_in) #1 wr_in = 1'b0;
        @(posedge clk_sys_in) #1;
    endtask

    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        @(posedge clk_sys_in) #1 rd_in = 1'b1;
        cmd_in = c;
        @(posedge clk_sys_in) #1 rd_in = 1'b0;
        @(posedge clk_sys_in) #1 v = rdata_out;
    endtask

    task automatic pulse(ref logic s);
        @(posedge clk_sys_in) #1 s = 1'b1;
        @(posedge clk_sys_in) #1 s = 1'b0;
        @(posedge clk_sys_in) #1;
    endtask

    // a refused write keeps the old value and raises the cml pair
    task automatic refused(input string name, input logic [7:0] c,
                           input logic [15:0] old);
        logic [15:0] v;
        chk({name, " cml"}, 16'h0001, {15'h0000, cml_out});
        chk({name, " ivd"}, 16'h0001, {15'h0000, invalid_data_out});
        chk({name, " alert"}, 16'h0000, {15'h0000, alert_n_out});
        rd(c, v);
        chk({name, " kept"}, old, v);
        pulse(clear_faults_in);
        chk({name, " alert off"}, 16'h0001, {15'h0000, alert_n_out});
    endtask

    task conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #(20 * 70000);
        failures++;
        conclude();
    end

    initial
    begin
        seed = 31;
        {wr_in, rd_in, store_all_in, restore_all_in, enable_in} = 5'h00;
        {clear_faults_in, alert_mask_in} = 2'h0;
        cmd_in = 8'h00;
        wdata_in = 16'h0000;
        never = 1'b1;
        rst_in = 1'b1;
        repeat (8) @(posedge clk_sys_in);
        #1 rst_in = 1'b0;
        chk("ramp_ms reset", 16'h0005, {9'h000, ramp_ms_out});
        chk("oe reset", 16'h0000, {15'h0000, output_enable_out});
        rd(`CMD_RAMP_TIME, w);
        chk("ramp reset", `RAMP_TIME_RESET, w);
        rd(`CMD_TIMEOUT_LIMIT, w);
        chk("limit reset", `TIMEOUT_LIMIT_RESET, w);
        rd(`CMD_TIMEOUT_ACTION, w);
        chk("action reset", {8'h00, `ACTION_RESET}, w);
        rd(8'h64, w);
        chk("unmapped", 16'h0000, w);
        // limit off, so every ramp value must be taken
        wr(`CMD_TIMEOUT_LIMIT, 16'h0000);
        for (i = 0; i < 30; i++)
        begin
            d = $random(seed);
            m = (i < 10) ? corner[i][6:0] : d[14:8];
            d[6:0] = m;
            wr(`CMD_RAMP_TIME, d);
            chk("ramp_ms", {9'h000, bucket(m)}, {9'h000, ramp_ms_out});
            rd(`CMD_RAMP_TIME, w);
            chk("ramp rd", {9'h000, m}, w);
            chk("no cml", 16'h0000, {15'h0000, cml_out});
        end
        wr(`CMD_RAMP_TIME, 16'h0005);
        wr(`CMD_TIMEOUT_LIMIT, 16'h000a);
        wr(`CMD_RAMP_TIME, 16'h0014);
        refused("ramp", `CMD_RAMP_TIME, 16'h0005);
        wr(`CMD_TIMEOUT_LIMIT, 16'h0002);
        refused("limit", `CMD_TIMEOUT_LIMIT, 16'h000a);
        wr(`CMD_TIMEOUT_LIMIT, 16'h0005);
        rd(`CMD_TIMEOUT_LIMIT, w);
        chk("limit equal", 16'h0005, w);
        prev = 16'h00bf;
        for (i = 0; i < 8; i++)
        begin
            d = {8'h00, 2'b10, i[2:0], 3'b000};
            wr(`CMD_TIMEOUT_ACTION, d);
            if (i == 0 || i == 7)
            begin
                prev = {d[15:3], 3'b111};
                rd(`CMD_TIMEOUT_ACTION, w);
                chk("action rd", prev, w);
            end
            else
                refused("retry", `CMD_TIMEOUT_ACTION, prev);
        end
        wr(`CMD_TIMEOUT_LIMIT, 16'h0000);
        wr(`CMD_RAMP_TIME, 16'h0009);
        wr(`CMD_TIMEOUT_ACTION, 16'h0007);
        pulse(store_all_in);
        wr(`CMD_RAMP_TIME, 16'h0003);
        wr(`CMD_TIMEOUT_ACTION, 16'h00bf);
        wr(`CMD_TIMEOUT_LIMIT, 16'h0032);
        pulse(restore_all_in);
        rd(`CMD_RAMP_TIME, w);
        chk("ramp restored", 16'h0009, w);
        rd(`CMD_TIMEOUT_ACTION, w);
        chk("action restored", 16'h0007, w);
        rd(`CMD_TIMEOUT_LIMIT, w);
        chk("limit restored", `TIMEOUT_LIMIT_RESET, w);
        // shortest limit with latch-off; plant never reaches uv level
        wr(`CMD_RAMP_TIME, 16'h0001);
        wr(`CMD_TIMEOUT_LIMIT, 16'h0001);
        wr(`CMD_TIMEOUT_ACTION, 16'h0087);
        enable_in = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1 chk("oe ramp", 16'h0001, {15'h0000, output_enable_out});
        chk("early", 16'h0000, {15'h0000, startup_timeout_flag_out});
        i = 0;
        while (startup_timeout_flag_out !== 1'b1 && i < 60000)
        begin
            @(posedge clk_sys_in) #1 i++;
        end
        chk("timeout", 16'h0001, {15'h0000, startup_timeout_flag_out});
        chk("oth", 16'h0001, {15'h0000, other_fault_out});
        chk("vout", 16'h0001, {15'h0000, output_volt_word_flag_out});
        chk("alert", 16'h0000, {15'h0000, alert_n_out});
        alert_mask_in = 1'b1;
        @(posedge clk_sys_in) #1;
        chk("masked", 16'h0001, {15'h0000, alert_n_out});
        alert_mask_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1 chk("oe off", 16'h0000, {15'h0000, output_enable_out});
        repeat (300) @(posedge clk_sys_in);
        #1 chk("latched", 16'h0000, {15'h0000, output_enable_out});
        enable_in = 1'b0;
        pulse(clear_faults_in);
        chk("cleared", 16'h0001, {15'h0000, alert_n_out});
        conclude();
    end
endmodule
